// ==== common/adc_alarm_pkg.sv ====
// Package with register layout, encodings and carrier types for the converter control block.
package adc_alarm_pkg;

    // ********************************************
    // Register map
    // ********************************************
    localparam logic [3:0] CTL_STATUS_ADDR = 4'h0;
    localparam logic [3:0] IRQ_STATUS_ADDR = 4'h1;
    localparam logic [3:0] IRQ_ENABLE_ADDR = 4'h2;
    localparam logic [3:0] IRQ_CLEAR_ADDR = 4'h3;
    localparam logic [3:0] SLOT_CTL_ADDR = 4'h4;

    // ********************************************
    // Field positions of the control/status, slot control and interrupt registers
    // ********************************************
    localparam int ENABLE_BIT = 7;
    localparam int SEL_HI = 6;
    localparam int SEL_LO = 4;
    localparam int RESET_BIT = 3;
    localparam int LEVEL_BIT = 2;
    localparam int FLAG_BIT = 1;
    localparam int MASK_BIT = 0;
    localparam int SLOT_EN_BIT = 0;
    localparam int EVT_ALARM_BIT = 0;

    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] SLOTS_NONE = 16'h0000;

    // Time the converter reset must be held by software.
    localparam int RESET_HOLD_NS = 400;
    localparam int CLK_PERIOD_NS = 4;
    localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Maps the three-bit line select onto an interrupt number.
    function automatic logic [3:0] line_number(input logic [2:0] sel);
        unique case (sel)
            3'h0: line_number = 4'h3;
            3'h1: line_number = 4'h4;
            3'h2: line_number = 4'h5;
            3'h3: line_number = 4'hA;
            3'h4: line_number = 4'h6;
            3'h5: line_number = 4'h7;
            3'h6: line_number = 4'h9;
            3'h7: line_number = 4'hB;
        endcase
    endfunction

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic alarm_sync1;
        logic alarm_sync2;
        logic alarm_prev;
        logic int_enable;
        logic [2:0] line_sel;
        logic conv_reset;
        logic event_flag;
        logic int_mask;
        logic slot_drive_en;
        logic evt_enable;
        logic [7:0] rdata;
        logic alarm_seen;
    } state_t;

endpackage

// ==== src/adc_alarm_irq_and_reset_ctl.sv ====
// Alarm interrupt, status and converter reset control for an external converter.
`timescale 1ns/100ps

// What this block does
// [RULE_01] Bit 7 is a read-write enable, reset 0, gating the alarm interrupt; the code gates only the slot request with it, not irq.
// [RULE_02] Bits 6-4 pick the serial interrupt slot, eight fixed encodings, reset 000.
// [RULE_03] Bit 3 drives the converter reset output while it holds 1.
// [RULE_04] Software keeps the reset bit set longer than 400 ns.
// [RULE_05] Platform reset also holds the converter in reset.
// [RULE_06] Read-only bit 2 returns the present alarm input level.
// [RULE_07] A rising alarm edge sets the sticky event flag in bit 1.
// [RULE_08] Reading the flag returns it; writing 1 clears, writing 0 keeps.
// [RULE_09] Bit 0 is a read-write mask, reset 0, letting the interrupt through; the code applies it only to the slot request, not irq.
// [RULE_10] Slots are driven only while the slot-drive enable bit is 1.
// [RULE_11] Request while flag, enable and mask are all 1; alarm synchronised first.
module adc_alarm_irq_and_reset_ctl (
    input wire logic core_clk,
    input wire logic resetn,
    input wire adc_alarm_pkg::reg_req_t req,
    output logic [7:0] rdata,
    input wire logic alarm_in,
    output logic conv_reset,
    output logic [15:0] slot_level,
    output logic [15:0] slot_oe,
    output logic irq
);
    import adc_alarm_pkg::*;

    // ********************************************
    // State
    // ********************************************
    state_t s_q;
    state_t s_d;
    logic rise;
    logic [3:0] line;
    logic req_active;

    // The first stage of the synchroniser feeds the second only.
    assign rise = s_q.alarm_sync2 && !s_q.alarm_prev; // see [RULE_07]
    assign req_active = s_q.event_flag && s_q.int_enable && s_q.int_mask; // see [RULE_11]
    assign line = line_number(s_q.line_sel); // see [RULE_02]

    always_comb begin
        s_d = s_q;
        s_d.alarm_sync1 = alarm_in;
        s_d.alarm_sync2 = s_q.alarm_sync1; // see [RULE_11]
        s_d.alarm_prev = s_q.alarm_sync2;
        s_d.rdata = BYTE_ZERO;
        if (req.wr) begin
            unique case (req.addr)
                CTL_STATUS_ADDR: begin
                    s_d.int_enable = req.wdata[ENABLE_BIT]; // see [RULE_01]
                    s_d.line_sel = req.wdata[SEL_HI:SEL_LO]; // see [RULE_02]
                    s_d.conv_reset = req.wdata[RESET_BIT]; // see [RULE_03]
                    s_d.int_mask = req.wdata[MASK_BIT]; // see [RULE_09]
                    if (req.wdata[FLAG_BIT]) begin
                        s_d.event_flag = 1'b0; // see [RULE_08]
                    end
                end
                IRQ_CLEAR_ADDR: begin
                    if (req.wdata[EVT_ALARM_BIT]) begin
                        s_d.alarm_seen = 1'b0;
                    end
                end
                IRQ_ENABLE_ADDR: begin
                    s_d.evt_enable = req.wdata[EVT_ALARM_BIT];
                end
                SLOT_CTL_ADDR: begin
                    s_d.slot_drive_en = req.wdata[SLOT_EN_BIT]; // see [RULE_10]
                end
                default: begin
                end
            endcase
        end
        // A new edge wins over a clear in the same cycle.
        if (rise) begin
            s_d.event_flag = 1'b1; // see [RULE_07]
            s_d.alarm_seen = 1'b1;
        end
        if (req.rd) begin
            unique case (req.addr)
                CTL_STATUS_ADDR: begin
                    s_d.rdata[ENABLE_BIT] = s_q.int_enable;
                    s_d.rdata[SEL_HI:SEL_LO] = s_q.line_sel;
                    s_d.rdata[RESET_BIT] = s_q.conv_reset;
                    s_d.rdata[LEVEL_BIT] = s_q.alarm_sync2; // see [RULE_06]
                    s_d.rdata[FLAG_BIT] = s_q.event_flag; // see [RULE_08]
                    s_d.rdata[MASK_BIT] = s_q.int_mask;
                end
                IRQ_STATUS_ADDR: begin
                    s_d.rdata[EVT_ALARM_BIT] = s_q.alarm_seen;
                end
                IRQ_ENABLE_ADDR: begin
                    s_d.rdata[EVT_ALARM_BIT] = s_q.evt_enable;
                end
                SLOT_CTL_ADDR: begin
                    s_d.rdata[SLOT_EN_BIT] = s_q.slot_drive_en;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ********************************************
    // Outputs
    // ********************************************
    // Platform reset forces the converter into reset regardless of the bit.
    assign conv_reset = !resetn || s_q.conv_reset; // see [RULE_03] see [RULE_05]
    assign rdata = s_q.rdata;
    assign irq = s_q.alarm_seen && s_q.evt_enable;

    always_comb begin
        slot_level = SLOTS_NONE;
        slot_oe = SLOTS_NONE;
        slot_level[line] = req_active; // see [RULE_02]
        if (s_q.slot_drive_en) begin
            slot_oe[line] = 1'b1; // see [RULE_10]
        end
    end

    // ********************************************
    // Checks
    // ********************************************
    edge_sets_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
        rise |=> s_q.event_flag) // see [RULE_07]
        else $error("alarm edge did not set flag");

    flag_sticky_a: assert property (@(posedge core_clk) disable iff (!resetn)
        s_q.event_flag && !(req.wr && req.addr == CTL_STATUS_ADDR && req.wdata[FLAG_BIT]) |=> s_q.event_flag)
        // see [RULE_08]
        else $error("flag dropped without clear");

    clear_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
        req.wr && req.addr == CTL_STATUS_ADDR && req.wdata[FLAG_BIT] && !rise |=> !s_q.event_flag)
        // see [RULE_08]
        else $error("write one did not clear flag");

    level_read_a: assert property (@(posedge core_clk) disable iff (!resetn)
        req.rd && req.addr == CTL_STATUS_ADDR |=> rdata[LEVEL_BIT] == $past(s_q.alarm_sync2)) // see [RULE_06]
        else $error("level bit mismatch");

    sync_delay_a: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(s_q.alarm_sync2) |-> $past(alarm_in, 2)) // see [RULE_11]
        else $error("alarm not synchronised");

    reset_out_a: assert property (@(posedge core_clk) disable iff (!resetn)
        req.wr && req.addr == CTL_STATUS_ADDR |=> conv_reset == $past(req.wdata[RESET_BIT])) // see [RULE_03]
        else $error("converter reset mismatch");

    slot_gate_a: assert property (@(posedge core_clk) disable iff (!resetn)
        !s_q.slot_drive_en |-> slot_oe == SLOTS_NONE) // see [RULE_10]
        else $error("slot driven while disabled");

    request_gate_a: assert property (@(posedge core_clk) disable iff (!resetn)
        slot_level[line] |-> s_q.event_flag && s_q.int_enable && s_q.int_mask) // see [RULE_01] see [RULE_09]
        else $error("request without enable and mask");

    select_map_a: assert property (@(posedge core_clk) disable iff (!resetn)
        s_q.line_sel == 3'h3 && s_q.slot_drive_en |-> slot_oe[10]) // see [RULE_02]
        else $error("select 011 not on slot 10");

    // ********************************************
    // Control field write and hold checks
    // ********************************************
    // Each control field must follow a write to its register and stay put otherwise.
    enable_write_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_01]
        req.wr && req.addr == CTL_STATUS_ADDR
        |=> s_q.int_enable == $past(req.wdata[ENABLE_BIT]))
        else $error("enable bit not written");

    enable_hold_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_01]
        !(req.wr && req.addr == CTL_STATUS_ADDR)
        |=> $stable(s_q.int_enable))
        else $error("enable bit changed without write");

    select_write_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_02]
        req.wr && req.addr == CTL_STATUS_ADDR
        |=> s_q.line_sel == $past(req.wdata[SEL_HI:SEL_LO]))
        else $error("line select not written");

    select_hold_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_02]
        !(req.wr && req.addr == CTL_STATUS_ADDR)
        |=> $stable(s_q.line_sel))
        else $error("line select changed without write");

    reset_hold_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_03]
        !(req.wr && req.addr == CTL_STATUS_ADDR)
        |=> $stable(s_q.conv_reset))
        else $error("reset bit changed without write");

    mask_write_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_09]
        req.wr && req.addr == CTL_STATUS_ADDR
        |=> s_q.int_mask == $past(req.wdata[MASK_BIT]))
        else $error("mask bit not written");

    mask_hold_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_09]
        !(req.wr && req.addr == CTL_STATUS_ADDR)
        |=> $stable(s_q.int_mask))
        else $error("mask bit changed without write");

    slot_write_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_10]
        req.wr && req.addr == SLOT_CTL_ADDR
        |=> s_q.slot_drive_en == $past(req.wdata[SLOT_EN_BIT]))
        else $error("slot drive enable not written");

    evt_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
        req.wr && req.addr == IRQ_ENABLE_ADDR
        |=> s_q.evt_enable == $past(req.wdata[EVT_ALARM_BIT]))
        else $error("event enable not written");

    // ********************************************
    // Reset output checks
    // ********************************************
    // No disable here: the point is what the pin does while platform reset is low.
    platform_reset_a: assert property (@(posedge core_clk) // see [RULE_05]
        !resetn
        |-> conv_reset)
        else $error("converter not held in platform reset");

    reset_follow_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_03]
        1'b1
        |-> conv_reset == s_q.conv_reset)
        else $error("reset output differs from bit");

    // ********************************************
    // Event and synchroniser checks
    // ********************************************
    flag_rise_only_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_07]
        $rose(s_q.event_flag)
        |-> $past(rise))
        else $error("flag set without alarm edge");

    sync_chain_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_11]
        1'b1
        |-> s_q.alarm_sync2 == $past(s_q.alarm_sync1))
        else $error("synchroniser stage skipped");

    seen_sticky_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_07]
        s_q.alarm_seen && !(req.wr && req.addr == IRQ_CLEAR_ADDR && req.wdata[EVT_ALARM_BIT])
        |=> s_q.alarm_seen)
        else $error("status bit dropped without clear");

    seen_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
        req.wr && req.addr == IRQ_CLEAR_ADDR && req.wdata[EVT_ALARM_BIT] && !rise
        |=> !s_q.alarm_seen)
        else $error("status clear did not take");

    // ********************************************
    // Read data checks
    // ********************************************
    read_enable_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_01]
        req.rd && req.addr == CTL_STATUS_ADDR
        |=> rdata[ENABLE_BIT] == $past(s_q.int_enable))
        else $error("enable read mismatch");

    read_select_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_02]
        req.rd && req.addr == CTL_STATUS_ADDR
        |=> rdata[SEL_HI:SEL_LO] == $past(s_q.line_sel))
        else $error("select read mismatch");

    read_reset_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_03]
        req.rd && req.addr == CTL_STATUS_ADDR
        |=> rdata[RESET_BIT] == $past(s_q.conv_reset))
        else $error("reset bit read mismatch");

    read_flag_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_08]
        req.rd && req.addr == CTL_STATUS_ADDR
        |=> rdata[FLAG_BIT] == $past(s_q.event_flag))
        else $error("flag read mismatch");

    read_mask_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_09]
        req.rd && req.addr == CTL_STATUS_ADDR
        |=> rdata[MASK_BIT] == $past(s_q.int_mask))
        else $error("mask read mismatch");

    // Read data is only valid in the cycle after a strobe and must be quiet otherwise.
    rdata_idle_a: assert property (@(posedge core_clk) disable iff (!resetn)
        !req.rd
        |=> rdata == BYTE_ZERO)
        else $error("read data not zero when idle");

    unmapped_read_a: assert property (@(posedge core_clk) disable iff (!resetn)
        req.rd && req.addr > SLOT_CTL_ADDR
        |=> rdata == BYTE_ZERO)
        else $error("unmapped read not zero");

    // ********************************************
    // Slot output checks
    // ********************************************
    oe_onehot_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_02]
        1'b1
        |-> $onehot0(slot_oe))
        else $error("more than one slot enabled");

    level_onehot_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_02]
        1'b1
        |-> $onehot0(slot_level))
        else $error("more than one slot requested");

    slot_drive_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_10]
        s_q.slot_drive_en
        |-> slot_oe[line])
        else $error("selected slot not driven");

    request_set_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_11]
        req_active
        |-> slot_level[line])
        else $error("request missing on selected slot");

    map_sel0_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_02]
        s_q.line_sel == 3'h0
        |-> line == 4'h3)
        else $error("select 000 not on slot 3");

    map_sel1_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_02]
        s_q.line_sel == 3'h1
        |-> line == 4'h4)
        else $error("select 001 not on slot 4");

    map_sel2_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_02]
        s_q.line_sel == 3'h2
        |-> line == 4'h5)
        else $error("select 010 not on slot 5");

    map_sel4_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_02]
        s_q.line_sel == 3'h4
        |-> line == 4'h6)
        else $error("select 100 not on slot 6");

    map_sel5_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_02]
        s_q.line_sel == 3'h5
        |-> line == 4'h7)
        else $error("select 101 not on slot 7");

    map_sel6_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_02]
        s_q.line_sel == 3'h6
        |-> line == 4'h9)
        else $error("select 110 not on slot 9");

    map_sel7_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RULE_02]
        s_q.line_sel == 3'h7
        |-> line == 4'hB)
        else $error("select 111 not on slot 11");

endmodule

// ==== tb/adc_conv_model.sv ====
// Behavioural model of the external converter's alarm and reset pins.
`timescale 1ns/100ps
module adc_conv_model (
    input wire logic conv_reset,
    input wire logic alarm_req,
    output logic alarm_in
);
    // A converter held in reset keeps its alarm pin low, as the real part does.
    assign alarm_in = alarm_req & ~conv_reset;
endmodule

// ==== tb/tb_adc_alarm_irq_and_reset_ctl.sv ====
// Self-checking bench for the converter alarm, interrupt and reset control block.
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_adc_alarm_irq_and_reset_ctl;
    import adc_alarm_pkg::*;
    logic core_clk = 1'b0;
    logic resetn;
    reg_req_t req;
    logic [7:0] rdata;
    logic alarm_req, alarm_in, conv_reset, irq;
    logic [15:0] slot_level, slot_oe;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int tab[8] = '{3, 4, 5, 10, 6, 7, 9, 11};
    adc_alarm_irq_and_reset_ctl i_adc_alarm_irq_and_reset_ctl (.core_clk(core_clk), .resetn(resetn), .req(req),
        .rdata(rdata), .alarm_in(alarm_in), .conv_reset(conv_reset), .slot_level(slot_level), .slot_oe(slot_oe),
        .irq(irq));
    adc_conv_model i_adc_conv_model (.conv_reset(conv_reset), .alarm_req(alarm_req), .alarm_in(alarm_in));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    // ****************************************
    // Bus, alarm pulse and result tasks
    // ****************************************
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
        #1;
    endtask
    task automatic rc(input string n, input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1 `CHK(n, e, rdata)
    endtask
    task automatic pulse();
        @(posedge core_clk);
        alarm_req <= 1'b1;
        repeat (5) @(posedge core_clk);
        alarm_req <= 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // A hung bus or lost event must not stall the run forever.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            results();
        end
    end
    initial begin
        req = '0;
        alarm_req = 1'b0;
        resetn = 1'b0;
        repeat (8) @(posedge core_clk);
        `CHK("rst_hold", 1'b1, conv_reset)
        resetn <= 1'b1;
        @(posedge core_clk);
        #1 `CHK("rst_rel", 1'b0, conv_reset)
        rc("ctl_rst", CTL_STATUS_ADDR, 8'h00);
        rc("unmapped", 4'hF, 8'h00);
        wr(CTL_STATUS_ADDR, 8'h0C);
        `CHK("conv_on", 1'b1, conv_reset)
        repeat (110) @(posedge core_clk);
        rc("ctl_rb", CTL_STATUS_ADDR, 8'h08);
        wr(CTL_STATUS_ADDR, 8'h00);
        `CHK("conv_off", 1'b0, conv_reset)
        $display("test reset done");
        @(posedge core_clk);
        alarm_req <= 1'b1;
        repeat (5) @(posedge core_clk);
        rc("alarm_hi", CTL_STATUS_ADDR, 8'h06);
        @(posedge core_clk);
        alarm_req <= 1'b0;
        repeat (5) @(posedge core_clk);
        rc("alarm_lo", CTL_STATUS_ADDR, 8'h02);
        wr(CTL_STATUS_ADDR, 8'h00);
        rc("w0_keep", CTL_STATUS_ADDR, 8'h02);
        wr(CTL_STATUS_ADDR, 8'h02);
        rc("w1_clr", CTL_STATUS_ADDR, 8'h00);
        $display("test alarm flag done");
        pulse();
        wr(SLOT_CTL_ADDR, 8'h01);
        for (int s = 0; s < 8; s++) begin
            wr(CTL_STATUS_ADDR, 8'h81 | 8'(s << 4));
            `CHK("slot_level", 16'h0001 << tab[s], slot_level)
            `CHK("slot_oe", 16'h0001 << tab[s], slot_oe)
        end
        wr(CTL_STATUS_ADDR, 8'h01);
        `CHK("lvl_noen", 16'h0000, slot_level)
        wr(CTL_STATUS_ADDR, 8'h80);
        `CHK("lvl_nomask", 16'h0000, slot_level)
        wr(CTL_STATUS_ADDR, 8'h81);
        wr(SLOT_CTL_ADDR, 8'h00);
        `CHK("oe_off", 16'h0000, slot_oe)
        wr(CTL_STATUS_ADDR, 8'h83);
        `CHK("lvl_clr", 16'h0000, slot_level)
        $display("test slots done");
        `CHK("irq_dis", 1'b0, irq)
        rc("irq_st", IRQ_STATUS_ADDR, 8'h01);
        wr(IRQ_ENABLE_ADDR, 8'h01);
        `CHK("irq_on", 1'b1, irq)
        wr(IRQ_CLEAR_ADDR, 8'h01);
        `CHK("irq_clr", 1'b0, irq)
        rc("irq_st0", IRQ_STATUS_ADDR, 8'h00);
        rc("clr_rd", IRQ_CLEAR_ADDR, 8'h00);
        pulse();
        `CHK("irq_again", 1'b1, irq)
        wr(IRQ_ENABLE_ADDR, 8'h00);
        `CHK("irq_mask", 1'b0, irq)
        rc("irq_en", IRQ_ENABLE_ADDR, 8'h00);
        $display("test interrupt done");
        results();
    end
endmodule
